// File: shared/ocd_pkg.sv
// Summary of operation
// - Reset clears every channel data register and drives every output code to zero.
// - Outputs stay at zero code until the first valid command executes.
// - Command fields 1101, 1110 and 1111 are power-down commands.
// - Power-down mask bits 7..0 select channels H..A; bits 11..8 are ignored.
// - Termination is high impedance, 100 kOhm or 2.5 kOhm per power-down code.
// - Powered-down channels lose linear circuitry; bias drops only when all eight are down.
// - Power-down leaves channel data registers unchanged.
// - Wake-up changes a data register only if the waking command writes it.
// - After reset the block is in register-only mode until switched.
// - Register-only channel write loads the data register and leaves the output.
// - Update-select with mask 0x00F moves channels A to D to outputs together.
// - Command field 1001 selects write-through mode; low twelve bits ignored.
// - Write-through channel write updates data register and output in one command.
// - Channel-A write loads and outputs channel A in either mode, mode unchanged.
// - Channel-A write also moves every other data register to its output.
// - Field 1000 selects register-only, 1001 write-through; mode persists.
// - Channel write has bit 15 zero and channel index in bits 14..12.
// - Update-select 1010 moves masked channels' data registers to outputs together.
// - Broadcast 1100 writes data to all registers and all outputs at once.
package ocd_pkg;

  localparam int NUM_CH     = 8;
  localparam int DATA_W     = 12;
  localparam int FRAME_BITS = 16;

  // Command field codes in bits 15..12 of the command word.
  localparam logic [3:0] CMD_REG_ONLY   = 4'h8;
  localparam logic [3:0] CMD_WRITE_THRU = 4'h9;
  localparam logic [3:0] CMD_UPD_SEL    = 4'hA;
  localparam logic [3:0] CMD_CHA_WRITE  = 4'hB;
  localparam logic [3:0] CMD_BROADCAST  = 4'hC;
  localparam logic [3:0] CMD_PD_HIZ     = 4'hD;
  localparam logic [3:0] CMD_PD_100K    = 4'hE;
  localparam logic [3:0] CMD_PD_2K5     = 4'hF;

  // Register byte offsets on the bus.
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_CMD       = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_TERM      = 8'h0C;
  localparam logic [7:0] REG_DATA_BASE = 8'h20;
  localparam logic [7:0] REG_OUT_BASE  = 8'h40;

  // Field positions.
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int STAT_MODE_BIT    = 0;
  localparam int STAT_BIAS_BIT    = 1;
  localparam int STAT_VALID_BIT   = 2;
  localparam int STAT_PD_LSB      = 8;

  // Reset values.
  localparam logic              CTRL_LINK_EN_RST = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST         = 12'h000;
  localparam logic [15:0]       CMD_RST          = 16'h0000;
  localparam logic              SYNC_N_RST       = 1'b1;
  localparam logic              SCLK_RST         = 1'b0;

  typedef enum logic [1:0] {
    OCD_TERM_DRIVEN,
    OCD_TERM_HIZ,
    OCD_TERM_100K,
    OCD_TERM_2K5
  } ocd_term_t;

  typedef struct packed {
    logic [3:0]        command_field;
    logic [DATA_W-1:0] data;
  } ocd_cmd_t;

endpackage : ocd_pkg

// File: src/ocd_sync.sv
module ocd_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;

  // Two stages; only the second stage is seen by any other logic.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_o  <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end

endmodule : ocd_sync

// File: src/ocd_frame_rx.sv
module ocd_frame_rx (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            sclk_i,
  input  wire logic            sync_n_i,
  input  wire logic            din_i,
  output ocd_pkg::ocd_cmd_t    cmd_o,
  output logic                 valid_o
);

  logic       sclk_d_ff;
  logic       sync_d_ff;
  logic       active_ff;
  logic [4:0] cnt_ff;
  logic [15:0] shift_ff;
  logic       nxt_active;
  logic [4:0] nxt_cnt;
  logic [15:0] nxt_shift;
  logic       nxt_valid;
  logic       sclk_fall;
  logic       sync_fall;
  logic       sync_rise;

  // Edges of the already synchronised link signals.
  assign sclk_fall = sclk_d_ff & ~sclk_i;
  assign sync_fall = sync_d_ff & ~sync_n_i;
  assign sync_rise = ~sync_d_ff & sync_n_i;

  // Shift on the falling link clock edge, where the host keeps data stable.
  always_comb begin
    nxt_active = active_ff;
    nxt_cnt    = cnt_ff;
    nxt_shift  = shift_ff;
    nxt_valid  = 1'b0;
    if (sync_fall) begin
      nxt_active = 1'b1;
      nxt_cnt    = 5'h00;
    end else if (active_ff && !sync_n_i && sclk_fall) begin
      nxt_shift = {shift_ff[14:0], din_i};
      if (cnt_ff != 5'(ocd_pkg::FRAME_BITS + 1)) begin
        nxt_cnt = cnt_ff + 5'h01;
      end
    end else if (sync_rise) begin
      nxt_active = 1'b0;
      // Short or overlong frames are dropped whole.
      nxt_valid  = active_ff && (cnt_ff == 5'(ocd_pkg::FRAME_BITS));
    end
  end

  // State registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_d_ff <= ocd_pkg::SCLK_RST;
      sync_d_ff <= ocd_pkg::SYNC_N_RST;
      active_ff <= 1'b0;
      cnt_ff    <= 5'h00;
      shift_ff  <= ocd_pkg::CMD_RST;
      valid_o   <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_i;
      sync_d_ff <= sync_n_i;
      active_ff <= nxt_active;
      cnt_ff    <= nxt_cnt;
      shift_ff  <= nxt_shift;
      valid_o   <= nxt_valid;
    end
  end

  assign cmd_o = ocd_pkg::ocd_cmd_t'(shift_ff);

endmodule : ocd_frame_rx

// File: src/ocd_top.sv
// The Wishbone slave port and the register offsets were decided locally.
module ocd_top (
  input  wire logic         CLK_SYS_I,
  input  wire logic         RST_N_I,
  input  wire logic         LINK_SCLK_I,
  input  wire logic         LINK_SYNC_N_I,
  input  wire logic         LINK_DIN_I,
  input  wire logic         WB_CYC_I,
  input  wire logic         WB_STB_I,
  input  wire logic         WB_WE_I,
  input  wire logic [7:0]   WB_ADR_I,
  input  wire logic [3:0]   WB_SEL_I,
  input  wire logic [31:0]  WB_DAT_I,
  output logic      [31:0]  WB_DAT_O,
  output logic              WB_ACK_O,
  output wire logic [95:0]  DAC_CODE_O,
  output wire logic [7:0]   CH_PD_O,
  output wire logic [15:0]  CH_TERM_O,
  output logic              BIAS_EN_O,
  output logic              WRITE_THROUGH_MODE_O
);

  localparam int NCH = ocd_pkg::NUM_CH;
  localparam int DW  = ocd_pkg::DATA_W;

  logic              sclk_s;
  logic              sync_n_s;
  logic              din_s;
  ocd_pkg::ocd_cmd_t rx_cmd;
  logic              rx_valid;

  logic              link_en_ff;
  logic              nxt_link_en;
  ocd_pkg::ocd_cmd_t last_cmd_ff;
  ocd_pkg::ocd_cmd_t nxt_last_cmd;
  ocd_pkg::ocd_cmd_t pend_cmd_ff;
  ocd_pkg::ocd_cmd_t nxt_pend_cmd;
  logic              pend_ff;
  logic              nxt_pend;
  logic              valid_seen_ff;
  logic              nxt_valid_seen;
  logic              nxt_mode;
  logic              nxt_bias;

  ocd_pkg::ocd_cmd_t exec_cmd;
  logic              exec_valid;
  logic              rx_take;
  logic              wb_req;
  logic              wb_wr;
  logic              wb_cmd_wr;
  logic              nxt_ack;
  logic [31:0]       nxt_rdata;

  logic [DW-1:0]     data_arr [NCH];
  logic [DW-1:0]     out_arr  [NCH];
  logic [NCH-1:0]    pd_vec;
  logic [NCH-1:0]    nxt_pd_vec;
  logic [2*NCH-1:0]  term_vec;
  logic [NCH-1:0]    ch_hit;

  // One-hot channel select from the channel_index_field. Decoding once,
  // outside the per-channel loop, keeps every channel on the same decoder.
  function automatic logic [NCH-1:0] ch_select(input logic [2:0] idx);
    ch_select = '0;
    ch_select[idx] = 1'b1;
  endfunction : ch_select

  // True when a bus address lies in the 32-byte window of eight channel words
  // that starts at base; the word index then comes from address bits 4..2.
  function automatic logic win_hit(input logic [7:0] adr, input logic [7:0] base);
    win_hit = (adr[7:5] == base[7:5]);
  endfunction : win_hit

  // Link pins come from another clock; each passes two flip-flops first.
  ocd_sync #(
    .W       (3),
    .RST_VAL ({ocd_pkg::SCLK_RST, ocd_pkg::SYNC_N_RST, 1'b0})
  ) u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .async_i ({LINK_SCLK_I, LINK_SYNC_N_I, LINK_DIN_I}),
    .sync_o  ({sclk_s, sync_n_s, din_s})
  );

  // The receiver works on the synchronised copies, so bit timing is judged
  // a few system cycles late, but equally late for all three pins.
  ocd_frame_rx u_rx (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RST_N_I),
    .sclk_i   (sclk_s),
    .sync_n_i (sync_n_s),
    .din_i    (din_s),
    .cmd_o    (rx_cmd),
    .valid_o  (rx_valid)
  );

  // Bus handshake: ack one cycle after the request, dropped the cycle after.
  // A write lands on the edge where the master sees ack high.
  assign wb_req    = WB_CYC_I & WB_STB_I;
  assign wb_wr     = wb_req & WB_WE_I & WB_ACK_O;
  assign wb_cmd_wr = wb_wr & (WB_ADR_I == ocd_pkg::REG_CMD) & (&WB_SEL_I[1:0]);
  assign nxt_ack   = wb_req & ~WB_ACK_O;

  // Command arbitration. A bus command wins the cycle; a colliding link frame
  // waits one slot. Frames are over a hundred cycles apart, so one slot is enough.
  // A second collision inside that slot would overwrite the parked frame, which
  // the link timing rules out.
  assign rx_take = rx_valid & link_en_ff;
  always_comb begin
    exec_valid   = 1'b0;
    exec_cmd     = pend_cmd_ff;
    nxt_pend     = pend_ff;
    nxt_pend_cmd = pend_cmd_ff;
    if (wb_cmd_wr) begin
      exec_valid = 1'b1;
      exec_cmd   = ocd_pkg::ocd_cmd_t'(WB_DAT_I[15:0]);
      if (rx_take) begin
        nxt_pend     = 1'b1;
        nxt_pend_cmd = rx_cmd;
      end
    end else if (pend_ff) begin
      exec_valid = 1'b1;
      nxt_pend   = rx_take;
      nxt_pend_cmd = rx_cmd;
    end else if (rx_take) begin
      exec_valid = 1'b1;
      exec_cmd   = rx_cmd;
    end
  end

  // Mode register; only fields 1000 and 1001 touch it.
  always_comb begin
    nxt_mode = WRITE_THROUGH_MODE_O;
    if (exec_valid && exec_cmd.command_field == ocd_pkg::CMD_REG_ONLY) begin
      nxt_mode = 1'b0;
    end else if (exec_valid && exec_cmd.command_field == ocd_pkg::CMD_WRITE_THRU) begin
      nxt_mode = 1'b1;
    end
  end

  // Control and bookkeeping registers.
  always_comb begin
    nxt_link_en    = link_en_ff;
    nxt_last_cmd   = last_cmd_ff;
    nxt_valid_seen = valid_seen_ff | exec_valid;
    if (wb_wr && WB_ADR_I == ocd_pkg::REG_CTRL && WB_SEL_I[0]) begin
      nxt_link_en = WB_DAT_I[ocd_pkg::CTRL_LINK_EN_BIT];
    end
    if (exec_valid) begin
      nxt_last_cmd = exec_cmd;
    end
  end

  // Bias stays on unless every channel sits in power-down.
  // It follows the next power-down state so that bias and the channel flags
  // always change on the same edge.
  assign nxt_bias = ~(&nxt_pd_vec);

  // Channel addressed by a channel write; only meaningful when bit 15 is clear.
  assign ch_hit = ch_select(exec_cmd.command_field[2:0]);

  // Per-channel data register, output latch and power-down state. A channel
  // only changes on an executed command, so outputs cannot drift between
  // frames and the zero code after reset holds until the first command.
  for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
    logic [DW-1:0]     data_ff;
    logic [DW-1:0]     out_ff;
    logic              pd_ff;
    ocd_pkg::ocd_term_t term_ff;
    logic [DW-1:0]     nxt_data;
    logic [DW-1:0]     nxt_out;
    logic              nxt_pd;
    ocd_pkg::ocd_term_t nxt_term;
    logic              upd;
    logic              in_mask;

    assign in_mask = exec_cmd.data[gi];

    always_comb begin
      nxt_data = data_ff;
      nxt_out  = out_ff;
      nxt_pd   = pd_ff;
      nxt_term = term_ff;
      upd      = 1'b0;
      if (exec_valid) begin
        unique case (exec_cmd.command_field)
          ocd_pkg::CMD_REG_ONLY, ocd_pkg::CMD_WRITE_THRU: begin
            upd = 1'b0;
          end
          ocd_pkg::CMD_UPD_SEL: begin
            upd = in_mask;
          end
          ocd_pkg::CMD_CHA_WRITE: begin
            if (gi == 0) begin
              nxt_data = exec_cmd.data;
            end
            upd = 1'b1;
          end
          ocd_pkg::CMD_BROADCAST: begin
            nxt_data = exec_cmd.data;
            upd      = 1'b1;
          end
          ocd_pkg::CMD_PD_HIZ, ocd_pkg::CMD_PD_100K, ocd_pkg::CMD_PD_2K5: begin
            // Data register is left alone in power-down.
            if (in_mask) begin
              nxt_pd = 1'b1;
              if (exec_cmd.command_field == ocd_pkg::CMD_PD_HIZ) begin
                nxt_term = ocd_pkg::OCD_TERM_HIZ;
              end else if (exec_cmd.command_field == ocd_pkg::CMD_PD_100K) begin
                nxt_term = ocd_pkg::OCD_TERM_100K;
              end else begin
                nxt_term = ocd_pkg::OCD_TERM_2K5;
              end
            end
          end
          default: begin
            // Bit 15 clear: channel write addressed by the channel_index_field.
            if (ch_hit[gi]) begin
              nxt_data = exec_cmd.data;
              upd      = WRITE_THROUGH_MODE_O;
            end
          end
        endcase
        // An output update also wakes the channel; a register-only write does not.
        if (upd) begin
          nxt_out  = nxt_data;
          nxt_pd   = 1'b0;
          nxt_term = ocd_pkg::OCD_TERM_DRIVEN;
        end
      end
    end

    // Reset clears data and drives a zero code until a command moves it.
    always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
        data_ff <= ocd_pkg::DATA_RST;
        out_ff  <= ocd_pkg::DATA_RST;
        pd_ff   <= 1'b0;
        term_ff <= ocd_pkg::OCD_TERM_DRIVEN;
      end else begin
        data_ff <= nxt_data;
        out_ff  <= nxt_out;
        pd_ff   <= nxt_pd;
        term_ff <= nxt_term;
      end
    end

    assign data_arr[gi]              = data_ff;
    assign out_arr[gi]               = out_ff;
    assign pd_vec[gi]                = pd_ff;
    assign nxt_pd_vec[gi]            = nxt_pd;
    assign term_vec[2*gi +: 2]       = term_ff;
    assign DAC_CODE_O[DW*gi +: DW]   = out_ff;
  end

  assign CH_PD_O   = pd_vec;
  assign CH_TERM_O = term_vec;

  // Read mux; unmapped addresses read as zero and are still acknowledged.
  // The mux follows the address every cycle; only the ack edge captures it.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (WB_ADR_I == ocd_pkg::REG_CTRL) begin
      nxt_rdata[ocd_pkg::CTRL_LINK_EN_BIT] = link_en_ff;
    end else if (WB_ADR_I == ocd_pkg::REG_CMD) begin
      nxt_rdata[15:0] = last_cmd_ff;
    end else if (WB_ADR_I == ocd_pkg::REG_STATUS) begin
      nxt_rdata[ocd_pkg::STAT_MODE_BIT]  = WRITE_THROUGH_MODE_O;
      nxt_rdata[ocd_pkg::STAT_BIAS_BIT]  = BIAS_EN_O;
      nxt_rdata[ocd_pkg::STAT_VALID_BIT] = valid_seen_ff;
      nxt_rdata[ocd_pkg::STAT_PD_LSB +: NCH] = pd_vec;
    end else if (WB_ADR_I == ocd_pkg::REG_TERM) begin
      nxt_rdata[2*NCH-1:0] = term_vec;
    end else if (win_hit(WB_ADR_I, ocd_pkg::REG_DATA_BASE)) begin
      nxt_rdata[DW-1:0] = data_arr[WB_ADR_I[4:2]];
    end else if (win_hit(WB_ADR_I, ocd_pkg::REG_OUT_BASE)) begin
      nxt_rdata[DW-1:0] = out_arr[WB_ADR_I[4:2]];
    end
  end

  // Shared registers; the read word is captured with ack and held by it.
  // Holding it lets a slow master take the word after ack has gone.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      WB_ACK_O             <= 1'b0;
      WB_DAT_O             <= 32'h0000_0000;
      link_en_ff           <= ocd_pkg::CTRL_LINK_EN_RST;
      last_cmd_ff          <= ocd_pkg::CMD_RST;
      pend_ff              <= 1'b0;
      pend_cmd_ff          <= ocd_pkg::CMD_RST;
      valid_seen_ff        <= 1'b0;
      WRITE_THROUGH_MODE_O <= 1'b0;
      BIAS_EN_O            <= 1'b1;
    end else begin
      WB_ACK_O             <= nxt_ack;
      WB_DAT_O             <= nxt_ack ? nxt_rdata : WB_DAT_O;
      link_en_ff           <= nxt_link_en;
      last_cmd_ff          <= nxt_last_cmd;
      pend_ff              <= nxt_pend;
      pend_cmd_ff          <= nxt_pend_cmd;
      valid_seen_ff        <= nxt_valid_seen;
      WRITE_THROUGH_MODE_O <= nxt_mode;
      BIAS_EN_O            <= nxt_bias;
    end
  end

endmodule : ocd_top

// File: verif/ocd_top_asserts.sv
module ocd_top_asserts (
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        LINK_SCLK_I,
  input wire logic        LINK_SYNC_N_I,
  input wire logic        LINK_DIN_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [95:0] DAC_CODE_O,
  input wire logic [7:0]  CH_PD_O,
  input wire logic [15:0] CH_TERM_O,
  input wire logic        BIAS_EN_O,
  input wire logic        WRITE_THROUGH_MODE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] dat_ff;
  logic [3:0]  age_ff;
  logic [7:0]  term_on;
  logic        cmd_wr;

  // Keep the last bus word and the cycles since the frame sync rose, saturating so it never wraps.
  always_ff @(posedge CLK_SYS_I) begin
    dat_ff <= WB_DAT_I;
    if (!RST_N_I || !LINK_SYNC_N_I) begin
      age_ff <= (!RST_N_I) ? 4'hF : 4'h0;
    end else if (age_ff != 4'hF) begin
      age_ff <= age_ff + 4'h1;
    end
  end

  // A channel shows a termination exactly when it is powered down.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      term_on[i] = |CH_TERM_O[2*i +: 2];
    end
  end

  // A command word accepted on the bus executes at the acknowledging edge.
  assign cmd_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O
                  && WB_ADR_I == ocd_pkg::REG_CMD && WB_SEL_I[1:0] == 2'b11;

  default clocking cb @(posedge CLK_SYS_I); endclocking

  sequence s_bus_cmd; $past(cmd_wr); endsequence
  sequence s_link_cmd; age_ff <= 4'hA; endsequence

  property p_reset_vals; !RST_N_I |=> DAC_CODE_O == 96'h0 && CH_PD_O == 8'h00
    && BIAS_EN_O && !WRITE_THROUGH_MODE_O; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong");
  property p_out_cause; disable iff (!RST_N_I)
    !$stable(DAC_CODE_O) |-> s_bus_cmd or s_link_cmd; endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved on no command");
  property p_bias; disable iff (!RST_N_I) BIAS_EN_O == (CH_PD_O != 8'hFF); endproperty
  a_bias: assert property (p_bias) else $error("bias enable wrong");
  property p_term; disable iff (!RST_N_I) term_on == CH_PD_O; endproperty
  a_term: assert property (p_term) else $error("termination without power-down");
  property p_pd_keep; disable iff (!RST_N_I)
    (CH_PD_O & ~$past(CH_PD_O)) != 8'h00 |-> $stable(DAC_CODE_O); endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("power-down changed a code");
  property p_pd_cmd; disable iff (!RST_N_I) cmd_wr && WB_DAT_I[15:14] == 2'b11
    && WB_DAT_I[13:12] != 2'b00 |=> (CH_PD_O & dat_ff[7:0]) == dat_ff[7:0]; endproperty
  a_pd_cmd: assert property (p_pd_cmd) else $error("masked channel not down");
  property p_wt_write; disable iff (!RST_N_I) cmd_wr && !WB_DAT_I[15] && WRITE_THROUGH_MODE_O
    |=> DAC_CODE_O[12*dat_ff[14:12] +: 12] == dat_ff[11:0]; endproperty
  a_wt_write: assert property (p_wt_write) else $error("write-through missed");
  property p_reg_only; disable iff (!RST_N_I) cmd_wr && !WB_DAT_I[15]
    && !WRITE_THROUGH_MODE_O |=> $stable(DAC_CODE_O); endproperty
  a_reg_only: assert property (p_reg_only) else $error("register write moved output");
  property p_mode_set; disable iff (!RST_N_I) cmd_wr && WB_DAT_I[15:13] == 3'b100
    |=> WRITE_THROUGH_MODE_O == dat_ff[12]; endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode not taken");
  property p_bcast; disable iff (!RST_N_I) cmd_wr && WB_DAT_I[15:12] == ocd_pkg::CMD_BROADCAST
    |=> DAC_CODE_O == {8{dat_ff[11:0]}} && CH_PD_O == 8'h00; endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast wrong");
endmodule : ocd_top_asserts

bind ocd_top ocd_top_asserts u_asserts (
  .CLK_SYS_I, .RST_N_I, .LINK_SCLK_I, .LINK_SYNC_N_I, .LINK_DIN_I, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .DAC_CODE_O, .CH_PD_O,
  .CH_TERM_O, .BIAS_EN_O, .WRITE_THROUGH_MODE_O
);

// File: verif/ocd_host_model.sv
module ocd_host_model (
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle with sync high, data low and the link clock stopped to save power.
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    din_o = 1'b0;
  end

  // One frame of n bits, most significant first, data changed just after each rise.
  task automatic send(input logic [15:0] c, input int n);
    #3 sync_n_o = 1'b0;
    #16;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      #4 din_o = c[15-i];
      #12 sclk_o = 1'b0;
      #16;
    end
    sync_n_o = 1'b1;
    din_o = 1'b0;
  endtask : send
endmodule : ocd_host_model

// File: verif/tb_octal_dac_command_decoder.sv
module tb_octal_dac_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [95:0] exp_wt = 96'hABC800FFF000400800C00123;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire  [95:0] code;
  wire  [7:0]  pd;
  wire  [15:0] term;
  wire         bias;
  wire         write_through_mode;
  wire         sclk;
  wire         sync_n;
  wire         din;
  wire  [9:0]  st = {pd, bias, write_through_mode};
  int          error_cnt = 0;
  int          n_tests = 0;

  always #2 clk = ~clk;

  ocd_top dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .LINK_SCLK_I(sclk), .LINK_SYNC_N_I(sync_n),
    .LINK_DIN_I(din), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DAC_CODE_O(code),
    .CH_PD_O(pd), .CH_TERM_O(term), .BIAS_EN_O(bias), .WRITE_THROUGH_MODE_O(write_through_mode)
  );

  ocd_host_model u_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [15:0] c);
    logic [31:0] q;
    wb(1'b1, ocd_pkg::REG_CMD, {16'h0000, c}, q);
    @(posedge clk);
  endtask : cmd

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk({64'h0, q}, {64'h0, e});
  endtask : rd

  // The link command lands a few cycles after sync rises, so allow a fixed margin.
  task automatic lnk(input logic [15:0] c, input int n);
    u_host.send(c, n);
    repeat (12) @(posedge clk);
  endtask : lnk

  task automatic t_reset;
    chk(code, 96'h0);
    chk({86'h0, st}, {86'h0, 10'h002});
    rd(ocd_pkg::REG_CTRL, 32'h1);
    rd(ocd_pkg::REG_STATUS, 32'h2);
    rd(8'h10, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_link;
    lnk(16'h0FFF, 16);
    lnk(16'h1C00, 16);
    lnk(16'h2800, 16);
    lnk(16'h3400, 16);
    lnk(16'h4777, 15);
    chk(code, 96'h0);
    rd(8'h24, 32'hC00);
    rd(8'h30, 32'h0);
    lnk(16'hA00F, 16);
    chk(code, 96'h000000000000400800C00FFF);
    $display("t_link done");
  endtask : t_link

  task automatic t_cha;
    cmd(16'h7ABC);
    chk(code, 96'h000000000000400800C00FFF);
    cmd(16'hB123);
    chk(code, 96'hABC000000000400800C00123);
    chk({86'h0, st}, {86'h0, 10'h002});
    $display("t_cha done");
  endtask : t_cha

  task automatic t_wt;
    cmd(16'h9ABC);
    chk({86'h0, st}, {86'h0, 10'h003});
    cmd(16'h6800);
    cmd(16'h5FFF);
    chk(code, exp_wt);
    cmd(16'h8123);
    chk({86'h0, st}, {86'h0, 10'h002});
    $display("t_wt done");
  endtask : t_wt

  // Each power-down code on channels A and H; codes and registers must survive.
  task automatic t_pd;
    logic [1:0] t;
    for (int k = 0; k < 3; k++) begin
      t = 2'(ocd_pkg::OCD_TERM_HIZ) + 2'(k);
      cmd({ocd_pkg::CMD_PD_HIZ + 4'(k), 4'h5, 8'h81});
      chk({86'h0, st}, {86'h0, 10'h206});
      chk({80'h0, term}, {80'h0, t, 12'h000, t});
      chk(code, exp_wt);
    end
    cmd(16'hF0FF);
    chk({86'h0, st}, {86'h0, 10'h3FC});
    rd(8'h20, 32'h123);
    cmd(16'h0456);
    cmd(16'hA001);
    chk(code, {exp_wt[95:12], 12'h456});
    chk({86'h0, st}, {86'h0, 10'h3FA});
    rd(8'h3C, 32'hABC);
    cmd(16'hC555);
    chk(code, {8{12'h555}});
    chk({86'h0, st}, {86'h0, 10'h002});
    $display("t_pd done");
  endtask : t_pd

  // Register readback, and a frame sent while the link is disabled must be lost.
  task automatic t_regs;
    logic [31:0] q;
    rd(ocd_pkg::REG_STATUS, 32'h6);
    rd(ocd_pkg::REG_CMD, 32'hC555);
    rd(ocd_pkg::REG_TERM, 32'h0);
    rd(8'h5C, 32'h555);
    wb(1'b1, ocd_pkg::REG_CTRL, 32'h0, q);
    lnk(16'h9000, 16);
    chk({86'h0, st}, {86'h0, 10'h002});
    wb(1'b1, ocd_pkg::REG_CTRL, 32'h1, q);
    lnk(16'h9000, 16);
    chk({86'h0, st}, {86'h0, 10'h003});
    $display("t_regs done");
  endtask : t_regs

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_link();
    t_cha();
    t_wt();
    t_pd();
    t_regs();
    finish_test();
  end
endmodule : tb_octal_dac_command_decoder
